// file: rtl/tac_pkg.sv
package tac_pkg;

  // ==========================================================
  // Register pointer codes
  localparam logic [1:0] PTR_LOW_LIMIT = 2'h2;
  localparam logic [1:0] PTR_HIGH_LIMIT = 2'h3;

  // ==========================================================
  // Limit register layout and reset values
  localparam int LIMIT_W = 16;
  localparam int LIMIT_MSB = 15;
  localparam logic [15:0] LOW_LIMIT_RST = 16'h8000;
  localparam logic [15:0] HIGH_LIMIT_RST = 16'h7FFF;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // ==========================================================
  // Trigger count codes
  localparam logic [1:0] TRIG_ONE = 2'h0;
  localparam logic [1:0] TRIG_TWO = 2'h1;
  localparam logic [1:0] TRIG_FOUR = 2'h2;
  localparam logic [1:0] TRIG_OFF = 2'h3;
  localparam logic [2:0] NEED_ONE = 3'h1;
  localparam logic [2:0] NEED_TWO = 3'h2;
  localparam logic [2:0] NEED_FOUR = 3'h4;
  localparam logic [2:0] CNT_MAX = 3'h7;

  // ==========================================================
  // Ready pulse timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RDY_PULSE_NS = 1000;
  localparam logic [7:0] RDY_PULSE_CYC =
    8'((RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Pin operating modes
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_CMP = 2'b01,
    MODE_RDY = 2'b10
  } tac_mode_e;

endpackage

// file: rtl/tac_limit_regs.sv
`timescale 1ns/100ps
module tac_limit_regs
  import tac_pkg::*;
(
  input logic core_clk,
  input logic rstn,
  input logic ce,
  input logic [1:0] reg_ptr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  output logic [15:0] reg_rdata,
  output logic [15:0] low_limit,
  output logic [15:0] high_limit
);

  // ==========================================================
  // Decode
  wire sel_low = (reg_ptr == PTR_LOW_LIMIT);
  wire sel_high = (reg_ptr == PTR_HIGH_LIMIT);
  wire wr_low = ce & reg_wr & sel_low;
  wire wr_high = ce & reg_wr & sel_high;
  wire [15:0] rd_mux = sel_low ? low_limit : (sel_high ? high_limit : RDATA_RST);

  logic [15:0] low_limit_r;
  logic [15:0] high_limit_r;
  logic [15:0] rdata_r;

  // ==========================================================
  // Storage
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      low_limit_r <= LOW_LIMIT_RST;
      high_limit_r <= HIGH_LIMIT_RST;
      rdata_r <= RDATA_RST;
    end
    else if (ce)
    begin
      if (wr_low)
        low_limit_r <= reg_wdata;
      if (wr_high)
        high_limit_r <= reg_wdata;
      rdata_r <= rd_mux;
    end
  end

  assign low_limit = low_limit_r;
  assign high_limit = high_limit_r;
  assign reg_rdata = rdata_r;

  // ==========================================================
  // Checks
  low_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(rstn) |-> low_limit == LOW_LIMIT_RST)
    else $error("low limit not at reset value");

  high_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(rstn) |-> high_limit == HIGH_LIMIT_RST)
    else $error("high limit not at reset value");

  low_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_low |=> low_limit == $past(reg_wdata) && $stable(high_limit))
    else $error("low limit write lost");

  high_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && sel_high |=> reg_rdata == $past(high_limit))
    else $error("high limit read wrong");

endmodule // tac_limit_regs

// file: rtl/tac_alert.sv
// Function
// - Two 16-bit limits held separately, both read as signed two's complement.
// - Low limit at pointer 2, resets to 8000h.
// - High limit at pointer 3, resets to 7FFFh.
// - High MSB 1 and low MSB 0 selects ready signalling on pin.
// - Ready signalling in single-shot drives pin with conversion status bit.
// - Ready signalling in continuous mode pulses pin per new result.
// - Serial clock line is never held low.
// - Register port works with standard, fast, high-speed single masters.
// - Both limits fully readable and writable bit by bit.
// - Trigger count selects one, two or four results; fourth code floats pin.
// - Polarity bit: 0 active low (default), 1 active high.
// - Status bit reads 0 while converting, 1 when idle.
`timescale 1ns/100ps
module tac_alert
  import tac_pkg::*;
(
  input logic core_clk,
  input logic rstn,
  input logic ce,
  input logic [1:0] reg_ptr,
  input logic [15:0] reg_wdata,
  input logic reg_wr,
  output logic [15:0] reg_rdata,
  input logic [15:0] result_data,
  input logic result_valid,
  input logic conv_busy,
  input logic single_shot_mode,
  input logic window_mode,
  input logic [1:0] trigger_count_select,
  input logic alert_latch_select,
  input logic alert_polarity_select,
  input logic data_read,
  input logic alert_response,
  output logic conversion_status_bit,
  output logic alert_o,
  output logic alert_oe,
  output logic scl_o,
  output logic scl_oe
);

  // ==========================================================
  // Helpers
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  function automatic logic [2:0] trig_need(input logic [1:0] sel);
    trig_need = (sel == TRIG_ONE) ? NEED_ONE : ((sel == TRIG_TWO) ? NEED_TWO : NEED_FOUR);
  endfunction

  // ==========================================================
  // Limit registers
  logic [15:0] low_limit;
  logic [15:0] high_limit;

  tac_limit_regs u_regs (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .reg_ptr(reg_ptr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rdata(reg_rdata),
    .low_limit(low_limit),
    .high_limit(high_limit)
  );

  // ==========================================================
  // State
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic alert_act_r;
  logic alert_act_nxt;
  logic [7:0] pulse_cnt_r;
  logic [7:0] pulse_cnt_nxt;
  logic status_r;
  logic alert_o_r;
  logic alert_oe_r;
  logic asserted;
  tac_mode_e mode;

  // ==========================================================
  // Decoding
  wire rdy_sel = high_limit[LIMIT_MSB] & ~low_limit[LIMIT_MSB];
  wire cmp_off = (trigger_count_select == TRIG_OFF);
  wire above = sgt(result_data, high_limit);
  wire below = sgt(low_limit, result_data);
  // Traditional mode has hysteresis: set above high, cleared only below low
  wire out_of_limit = window_mode ? (above | below) : above;
  wire back_in = window_mode ? ~(above | below) : below;
  wire [2:0] cnt_inc = (cnt_r == CNT_MAX) ? CNT_MAX : 3'(cnt_r + 3'h1);
  wire trig_hit = cnt_inc >= trig_need(trigger_count_select);
  wire is_cmp = (mode == MODE_CMP);
  wire is_rdy = (mode == MODE_RDY);
  wire alert_clear = data_read | alert_response;
  wire pulse_on = (pulse_cnt_r != 8'h00);
  wire pin_level = alert_polarity_select ? asserted : ~asserted;

  assign mode = cmp_off ? MODE_OFF : (rdy_sel ? MODE_RDY : MODE_CMP);

  // ==========================================================
  // Successive out-of-limit counter
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!is_cmp)
      cnt_nxt = 3'h0;
    else if (result_valid)
      cnt_nxt = out_of_limit ? cnt_inc : 3'h0;
  end

  // ==========================================================
  // Alert flag, set wins over clear
  always_comb
  begin
    alert_act_nxt = alert_act_r;
    if (!is_cmp)
      alert_act_nxt = 1'b0;
    else if (result_valid && out_of_limit && trig_hit)
      alert_act_nxt = 1'b1;
    else if (alert_latch_select)
    begin
      if (alert_clear)
        alert_act_nxt = 1'b0;
    end
    else if (result_valid && back_in)
      alert_act_nxt = 1'b0;
  end

  // ==========================================================
  // Ready pulse timer
  // A new result restarts a pulse that is still running
  always_comb
  begin
    pulse_cnt_nxt = pulse_on ? 8'(pulse_cnt_r - 8'h01) : 8'h00;
    if (!is_rdy || single_shot_mode)
      pulse_cnt_nxt = 8'h00;
    else if (result_valid)
      pulse_cnt_nxt = RDY_PULSE_CYC;
  end

  // ==========================================================
  // Pin meaning per mode
  always_comb
  begin
    case (mode)
      MODE_CMP: asserted = alert_act_r;
      MODE_RDY: asserted = single_shot_mode ? status_r : pulse_on;
      default: asserted = 1'b0;
    endcase
  end

  // ==========================================================
  // Comparator state
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cnt_r <= 3'h0;
      alert_act_r <= 1'b0;
      pulse_cnt_r <= 8'h00;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      alert_act_r <= alert_act_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // ==========================================================
  // Pin and status outputs
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      status_r <= 1'b1;
      alert_o_r <= 1'b1;
      alert_oe_r <= 1'b0;
    end
    else if (ce)
    begin
      status_r <= ~conv_busy;
      alert_o_r <= pin_level;
      alert_oe_r <= ~cmp_off;
    end
  end

  assign conversion_status_bit = status_r;
  assign alert_o = alert_o_r;
  assign alert_oe = alert_oe_r;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;

  // ==========================================================
  // Checks
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  scl_released_a: assert property (!scl_oe)
    else $error("serial clock driven");

  status_read_a: assert property (ce |=> conversion_status_bit == !$past(conv_busy))
    else $error("status bit wrong");

  float_disabled_a: assert property (ce && cmp_off |=> !alert_oe && !alert_act_r)
    else $error("pin driven while comparator off");

  pol_level_a: assert property (ce && is_cmp |=>
    alert_o == ($past(alert_polarity_select) ? $past(alert_act_r) : !$past(alert_act_r)))
    else $error("alert level does not follow polarity");

  one_shot_a: assert property (ce && is_cmp && result_valid && out_of_limit &&
    trigger_count_select == TRIG_ONE |=> alert_act_r)
    else $error("single trigger missed");

  four_need_a: assert property (ce && is_cmp && trigger_count_select == TRIG_FOUR &&
    result_valid && !alert_act_r && cnt_r < 3'h3 |=> !alert_act_r)
    else $error("four-count trigger too early");

  latch_hold_a: assert property (ce && is_cmp && alert_latch_select && alert_act_r &&
    !alert_clear |=> alert_act_r)
    else $error("latched alert dropped");

  nolatch_clear_a: assert property (ce && is_cmp && !alert_latch_select &&
    result_valid && back_in && !out_of_limit |=> !alert_act_r)
    else $error("alert not cleared in range");

  rdy_single_a: assert property (ce && is_rdy && single_shot_mode |=>
    alert_o == ($past(alert_polarity_select) ? $past(status_r) : !$past(status_r)))
    else $error("ready pin not following status");

  rdy_pulse_a: assert property (ce && is_rdy && !single_shot_mode && result_valid |=>
    pulse_cnt_r == RDY_PULSE_CYC ##1 (!ce || (pulse_on && asserted)))
    else $error("ready pulse missing");

  // Limit comparisons below are written out apart from the decode on purpose
  oe_drive_a: assert property (ce && !cmp_off |=> alert_oe)
    else $error("pin not driven while comparator on");

  two_wait_a: assert property (ce && is_cmp && trigger_count_select == TRIG_TWO &&
    result_valid && !alert_act_r && cnt_r == 3'h0 |=> !alert_act_r)
    else $error("two-count trigger too early");

  two_hit_a: assert property (ce && is_cmp && trigger_count_select == TRIG_TWO &&
    result_valid && !window_mode && cnt_r == 3'h1 &&
    $signed(result_data) > $signed(high_limit) |=> alert_act_r)
    else $error("two-count trigger missed");

  four_hit_a: assert property (ce && is_cmp && trigger_count_select == TRIG_FOUR &&
    result_valid && window_mode && cnt_r == 3'h3 &&
    $signed(result_data) < $signed(low_limit) |=> alert_act_r)
    else $error("four-count trigger missed");

  count_clear_a: assert property (ce && is_cmp && !window_mode && result_valid &&
    $signed(result_data) <= $signed(high_limit) |=> cnt_r == 3'h0)
    else $error("count kept after in-limit result");

  window_low_a: assert property (ce && is_cmp && window_mode && result_valid &&
    $signed(result_data) < $signed(low_limit) |=> cnt_r != 3'h0)
    else $error("low excursion not counted");

  latch_clear_a: assert property (ce && is_cmp && alert_latch_select && alert_clear &&
    !result_valid |=> !alert_act_r)
    else $error("latched alert not cleared");

  rdy_select_a: assert property (trigger_count_select != TRIG_OFF |->
    (mode == MODE_RDY) == ($signed(high_limit) < 0 && $signed(low_limit) >= 0))
    else $error("ready signalling select wrong");

  rdy_idle_a: assert property (ce && !is_cmp |=> !alert_act_r && cnt_r == 3'h0)
    else $error("comparator active outside comparison use");

  pulse_step_a: assert property (ce && is_rdy && !single_shot_mode && !result_valid &&
    pulse_on |=> pulse_cnt_r == $past(pulse_cnt_r) - 8'h01)
    else $error("ready pulse timer not counting down");

  pulse_end_a: assert property (ce && is_rdy && !single_shot_mode && !result_valid &&
    pulse_cnt_r == 8'h01 |=> !pulse_on)
    else $error("ready pulse too long");

  off_level_a: assert property (ce && cmp_off |=>
    alert_o == !$past(alert_polarity_select))
    else $error("idle pin level wrong while off");

  cmp_alert_c: cover property (is_cmp && $rose(alert_act_r));
  latch_clear_c: cover property (alert_latch_select && alert_act_r ##1 !alert_act_r);
  rdy_pulse_c: cover property (is_rdy && !single_shot_mode && $rose(pulse_on));
  off_float_c: cover property (cmp_off && $fell(alert_oe));
  rdy_single_c: cover property (is_rdy && single_shot_mode && $changed(alert_o));

endmodule // tac_alert

// file: tb/tac_host_model.sv
`timescale 1ns/100ps
module tac_host_model
  import tac_pkg::*;
(
  input logic core_clk,
  input logic scl_oe,
  output logic scl_line,
  output logic [1:0] reg_ptr,
  output logic [15:0] reg_wdata,
  output logic reg_wr
);
  // Clock wire has a pull-up; the device may only release it
  assign scl_line = scl_oe ? 1'b0 : 1'b1;
  initial
  begin
    reg_ptr = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
  end
  task automatic wr(input logic [1:0] p, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_ptr = p;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic point(input logic [1:0] p);
    @(posedge core_clk);
    #1;
    reg_ptr = p;
  endtask
endmodule // tac_host_model

// file: tb/threshold_alert_comparator_tb.sv
`timescale 1ns/100ps
module threshold_alert_comparator_tb;
  import tac_pkg::*;
  logic core_clk, rstn, ce, reg_wr, rv, busy, ss, win, lat, pol, drd, ares;
  logic [1:0] ptr, trig;
  logic [15:0] wdata, rdata, rd;
  logic st, al, al_oe, scl_o, scl_oe, scl_line;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  tac_host_model u_host (.core_clk(core_clk), .scl_oe(scl_oe), .scl_line(scl_line),
    .reg_ptr(ptr), .reg_wdata(wdata), .reg_wr(reg_wr));
  tac_alert u_dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_ptr(ptr),
    .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rdata(rdata), .result_data(rd),
    .result_valid(rv), .conv_busy(busy), .single_shot_mode(ss), .window_mode(win),
    .trigger_count_select(trig), .alert_latch_select(lat),
    .alert_polarity_select(pol), .data_read(drd), .alert_response(ares),
    .conversion_status_bit(st), .alert_o(al), .alert_oe(al_oe), .scl_o(scl_o),
    .scl_oe(scl_oe));
  // ==========================================================
  // Clock, timeout and reporting
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // ==========================================================
  // Access tasks
  task automatic rd_chk(input logic [1:0] p, input logic [15:0] e);
    u_host.point(p);
    @(posedge core_clk);
    #1;
    chk("reg_rdata", e, rdata);
  endtask
  task automatic res(input logic [15:0] d);
    @(posedge core_clk);
    #1;
    rd = d;
    rv = 1'b1;
    @(posedge core_clk);
    #1;
    rv = 1'b0;
    rd = ~d;
  endtask
  task automatic pin(input logic e);
    @(posedge core_clk);
    #1;
    chk("alert_o", {15'h0000, e}, {15'h0000, al});
  endtask
  task automatic pulse(input logic resp);
    @(posedge core_clk);
    #1;
    drd = ~resp;
    ares = resp;
    @(posedge core_clk);
    #1;
    drd = 1'b0;
    ares = 1'b0;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    {rstn, rv, busy, win, lat, pol, drd, ares} = '0;
    ce = 1'b1;
    ss = 1'b1;
    trig = TRIG_OFF;
    rd = 16'h0000;
    repeat (10) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("alert_oe", 16'h0000, {15'h0000, al_oe});
    rd_chk(PTR_LOW_LIMIT, 16'h8000);
    rd_chk(PTR_HIGH_LIMIT, 16'h7FFF);
    for (int i = 0; i < 2; i++)
    begin
      u_host.wr(PTR_LOW_LIMIT, i ? 16'h5A5A : 16'hA5A5);
      u_host.wr(PTR_HIGH_LIMIT, i ? 16'hA5A5 : 16'h5A5A);
      rd_chk(PTR_LOW_LIMIT, i ? 16'h5A5A : 16'hA5A5);
      rd_chk(PTR_HIGH_LIMIT, i ? 16'hA5A5 : 16'h5A5A);
    end
    // Clock enable low: a write must not land
    ce = 1'b0;
    u_host.wr(PTR_LOW_LIMIT, 16'h0F0F);
    ce = 1'b1;
    rd_chk(PTR_LOW_LIMIT, 16'h5A5A);
    u_host.wr(2'h1, 16'h1234);
    rd_chk(2'h1, 16'h0000);
    u_host.wr(PTR_LOW_LIMIT, 16'hFF9C);
    u_host.wr(PTR_HIGH_LIMIT, 16'h0064);
    trig = TRIG_TWO;
    res(16'h0065);
    pin(1'b1);
    chk("alert_oe", 16'h0001, {15'h0000, al_oe});
    res(16'h0065);
    pin(1'b0);
    res(16'h8000);
    pin(1'b1);
    win = 1'b1;
    trig = TRIG_FOUR;
    repeat (3)
    begin
      res(16'hFF00);
      pin(1'b1);
    end
    res(16'hFF00);
    pin(1'b0);
    res(16'h0000);
    pin(1'b1);
    lat = 1'b1;
    trig = TRIG_ONE;
    res(16'h0200);
    pin(1'b0);
    res(16'h0000);
    pin(1'b0);
    pulse(1'b0);
    pin(1'b1);
    res(16'h0200);
    pulse(1'b1);
    pin(1'b1);
    lat = 1'b0;
    pol = 1'b1;
    res(16'h0200);
    pin(1'b1);
    trig = TRIG_OFF;
    pin(1'b0);
    chk("alert_oe", 16'h0000, {15'h0000, al_oe});
    // Mid-run reset brings both limits back to their reset values
    rstn = 1'b0;
    @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk("alert_o", 16'h0001, {15'h0000, al});
    rd_chk(PTR_LOW_LIMIT, 16'h8000);
    rd_chk(PTR_HIGH_LIMIT, 16'h7FFF);
    // Ready signalling; limits rewritten as after a gain change
    u_host.wr(PTR_HIGH_LIMIT, 16'h8000);
    u_host.wr(PTR_LOW_LIMIT, 16'h0000);
    {trig, pol, busy} = {TRIG_ONE, 1'b0, 1'b1};
    repeat (2) @(posedge core_clk);
    pin(1'b1);
    chk("status", 16'h0000, {15'h0000, st});
    busy = 1'b0;
    repeat (2) @(posedge core_clk);
    pin(1'b0);
    chk("status", 16'h0001, {15'h0000, st});
    ss = 1'b0;
    repeat (2) @(posedge core_clk);
    res(16'h1111);
    pin(1'b0);
    repeat (RDY_PULSE_CYC - 2) @(posedge core_clk);
    pin(1'b0);
    pin(1'b1);
    chk("scl_line", 16'h0001, {15'h0000, scl_line});
    chk("scl_o", 16'h0000, {15'h0000, scl_o});
    final_report();
  end
endmodule // threshold_alert_comparator_tb
